// >>> logic/dco_defs.svh
// Constants for the configuration overlay command handler
`ifndef DCO_DEFS_SVH
`define DCO_DEFS_SVH
`define DCO_OPCODE 8'hb1
`define DCO_SUB_RESTORE 8'hc0
`define DCO_SUB_FREEZE 8'hc1
`define DCO_SUB_IDENTIFY 8'hc2
`define DCO_SUB_SET 8'hc3
`define DCO_SIGNATURE 8'ha5
`define DCO_WORDS 9'h100
`define DCO_LAST_WORD 8'hff
`define DCO_W_DMA 8'h01
`define DCO_W_UDMA 8'h02
`define DCO_W_LBA0 8'h03
`define DCO_W_LBA3 8'h06
`define DCO_W_CMD 8'h07
`define DCO_W_SATA 8'h08
`define DCO_W_ID63 8'h3f
`define DCO_W_ID82 8'h52
`define DCO_W_ID83 8'h53
`define DCO_W_ID84 8'h54
`define DCO_W_ID88 8'h58
`define DCO_ERR_ABORT 8'h04
`define DCO_ST_READY 8'h40
`define DCO_ST_DRQ 8'h08
`define DCO_ST_ERR 8'h01
`define DCO_ST_BUSY 8'h80
`define DCO_RSN_HPA 8'h06
`define DCO_RSN_BAD 8'h01
`endif

// >>> logic/dco_pkg.sv
// Types for the configuration overlay command handler
package dco_pkg;
  typedef enum logic [2:0] {
    DCO_IDLE = 3'b000,
    DCO_DECODE = 3'b001,
    DCO_XFER = 3'b011,
    DCO_CHECK = 3'b010,
    DCO_DONE = 3'b110
  } dco_state_t;
  typedef struct packed {
    logic [7:0] reason;
    logic [7:0] word_loc;
    logic [7:0] bit_loc;
  } dco_abort_t;
  typedef struct packed {
    logic [15:0] w63;
    logic [15:0] w82;
    logic [15:0] w83;
    logic [15:0] w84;
    logic [15:0] w88;
  } dco_ident_t;
endpackage : dco_pkg

// >>> logic/dco_checksum.sv
// Running modulo-256 byte sum over the overlay structure
`timescale 1ns/1ps
module dco_checksum (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic add,
  input wire logic [15:0] word,
  // Result
  output logic [7:0] sum
);
  logic [7:0] next_sum;
  always_comb begin
    next_sum = sum;
    if (clear) begin
      next_sum = 8'h00;
    end else if (add) begin
      next_sum = sum + word[7:0] + word[15:8];
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sum <= 8'h00;
    end else begin
      sum <= next_sum;
    end
  end
endmodule : dco_checksum

// >>> logic/dco_cmd_handler.sv
// Configuration overlay command handler: decode, identify, set, lock
// What this block does
// R1 - Opcode B1h selects the overlay command family
// R2 - Feature C0h-C3h picks the subcommand
// R3 - Restore drops every set reduction
// R4 - Freeze lock aborts all later overlay subcommands
// R5 - Lock cleared only by power removal
// R6 - Identify sends 512 bytes by PIO in
// R7 - Normal identify reduced, overlay identify full
// R8 - Set alters only words 63,82,83,84,88
// R9 - Cleared bit disables that capability
// R10 - Set bit not offered is ignored
// R11 - Restriction breach aborts the set
// R12 - Abort reports reason, word, bit locations
// R13 - HPA present and LBA change aborts 06h
// R14 - Last word low byte holds A5h
// R15 - Last word high byte is checksum
// R16 - Abort sets ABRT and ERR only
// R17 - Unknown feature value aborts
`timescale 1ns/1ps
`include "dco_defs.svh"
module dco_cmd_handler import dco_pkg::*; #(
  parameter logic [15:0] FULL_DMA = 16'h0007,
  parameter logic [15:0] FULL_UDMA = 16'h007f,
  parameter logic [15:0] FULL_CMD = 16'h1bbf,
  parameter logic [15:0] FULL_SATA = 16'h0017,
  parameter logic [47:0] FULL_MAX_LBA = 48'h0000_1000_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic power_on_rstn,
  // Taskfile command strobe and registers
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] feature,
  input wire logic hpa_active,
  // PIO data port
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  // Taskfile result registers
  output logic [7:0] command_error_flags,
  output logic [7:0] command_status_flags,
  output logic [7:0] sector_count,
  output logic [7:0] cyl_high,
  output logic [7:0] cyl_low,
  // Capability words for ordinary identify
  output dco_ident_t ident_words,
  output logic [15:0] dma_modes,
  output logic [15:0] udma_modes,
  output logic [15:0] cmd_sets,
  output logic [15:0] sata_sets,
  output logic frozen
);
  // ************************************************
  // State
  // ************************************************
  dco_state_t state, next_state;
  logic [7:0] sub, next_sub;
  logic [8:0] idx, next_idx;
  logic [15:0] rx_dma, next_rx_dma, rx_udma, next_rx_udma;
  logic [15:0] rx_cmd, next_rx_cmd, rx_sata, next_rx_sata;
  logic [47:0] rx_lba, next_rx_lba;
  logic [15:0] next_dma_modes, next_udma_modes, next_cmd_sets, next_sata_sets;
  logic [15:0] next_data_out;
  logic [7:0] next_err, next_stat, next_sc, next_ch, next_cl;
  logic next_frozen;
  logic [7:0] csum;
  logic [15:0] tx_word;
  logic last;

  // ************************************************
  // Overlay structure image
  // ************************************************
  function automatic logic [15:0] full_word(input logic [7:0] w, input logic [7:0] ck);
    case (w)
      8'h00: full_word = 16'h0002;
      `DCO_W_DMA: full_word = FULL_DMA;
      `DCO_W_UDMA: full_word = FULL_UDMA;
      8'h03: full_word = FULL_MAX_LBA[15:0];
      8'h04: full_word = FULL_MAX_LBA[31:16];
      8'h05: full_word = FULL_MAX_LBA[47:32];
      `DCO_W_CMD: full_word = FULL_CMD;
      `DCO_W_SATA: full_word = FULL_SATA;
      // R14 signature byte
      // R15 checksum byte
      `DCO_LAST_WORD: full_word = {ck, `DCO_SIGNATURE};
      default: full_word = 16'h0000;
    endcase
  endfunction : full_word

  assign last = (idx == 9'(`DCO_LAST_WORD));
  // R15 two's complement of sum
  assign tx_word = full_word(idx[7:0], 8'(8'h00 - csum - `DCO_SIGNATURE));

  dco_checksum u_sum (
    .clk(clk),
    .rstn(rstn),
    .clear(state == DCO_DECODE),
    .add((state == DCO_XFER) && (sub == `DCO_SUB_IDENTIFY) && data_rd && !last),
    .word(tx_word),
    .sum(csum)
  );

  // ************************************************
  // Next-state logic
  // ************************************************
  always_comb begin
    next_state = state;
    next_sub = sub;
    next_idx = idx;
    next_rx_dma = rx_dma;
    next_rx_udma = rx_udma;
    next_rx_cmd = rx_cmd;
    next_rx_sata = rx_sata;
    next_rx_lba = rx_lba;
    next_dma_modes = dma_modes;
    next_udma_modes = udma_modes;
    next_cmd_sets = cmd_sets;
    next_sata_sets = sata_sets;
    next_data_out = data_out;
    next_err = command_error_flags;
    next_stat = command_status_flags;
    next_sc = sector_count;
    next_ch = cyl_high;
    next_cl = cyl_low;
    next_frozen = frozen;
    case (state)
      DCO_IDLE: begin
        // R1 opcode match
        if (cmd_wr && cmd_code == `DCO_OPCODE) begin
          next_sub = feature;
          next_stat = `DCO_ST_BUSY;
          next_err = 8'h00;
          next_state = DCO_DECODE;
        end
      end
      DCO_DECODE: begin
        next_idx = 9'h000;
        next_state = DCO_DONE;
        next_stat = `DCO_ST_READY | `DCO_ST_ERR;
        // R16 abort flags
        next_err = `DCO_ERR_ABORT;
        next_sc = `DCO_RSN_BAD;
        next_ch = 8'h00;
        next_cl = 8'h00;
        // R4 locked aborts all
        if (!frozen) begin
          // R2 subcommand select
          case (sub)
            `DCO_SUB_RESTORE: begin
              // R13 protected area guard
              if (hpa_active) begin
                next_sc = `DCO_RSN_HPA;
                next_ch = `DCO_W_LBA0;
              end else begin
                // R3 back to full set
                next_dma_modes = FULL_DMA;
                next_udma_modes = FULL_UDMA;
                next_cmd_sets = FULL_CMD;
                next_sata_sets = FULL_SATA;
                next_err = 8'h00;
                next_sc = 8'h00;
                next_stat = `DCO_ST_READY;
              end
            end
            `DCO_SUB_FREEZE: begin
              next_frozen = 1'b1;
              next_err = 8'h00;
              next_sc = 8'h00;
              next_stat = `DCO_ST_READY;
            end
            `DCO_SUB_IDENTIFY, `DCO_SUB_SET: begin
              // R6 PIO data phase
              next_err = 8'h00;
              next_sc = 8'h00;
              next_stat = `DCO_ST_READY | `DCO_ST_DRQ;
              next_data_out = full_word(8'h00, 8'h00);
              next_state = DCO_XFER;
            end
            // R17 reserved feature
            default: begin
            end
          endcase
        end
      end
      DCO_XFER: begin
        if (sub == `DCO_SUB_IDENTIFY && data_rd) begin
          next_idx = 9'(idx + 9'h001);
          next_data_out = full_word(8'(idx + 9'h001), 8'(8'h00 - csum - tx_word[7:0]
            - tx_word[15:8] - `DCO_SIGNATURE));
        end else if (sub == `DCO_SUB_SET && data_wr) begin
          next_idx = 9'(idx + 9'h001);
          // R8 only capability words kept
          case (idx[7:0])
            `DCO_W_DMA: next_rx_dma = data_in;
            `DCO_W_UDMA: next_rx_udma = data_in;
            8'h03: next_rx_lba[15:0] = data_in;
            8'h04: next_rx_lba[31:16] = data_in;
            8'h05: next_rx_lba[47:32] = data_in;
            `DCO_W_CMD: next_rx_cmd = data_in;
            `DCO_W_SATA: next_rx_sata = data_in;
            default: begin
            end
          endcase
        end
        if ((data_rd || data_wr) && last) begin
          next_stat = `DCO_ST_BUSY;
          next_state = (sub == `DCO_SUB_SET) ? DCO_CHECK : DCO_DONE;
        end
      end
      DCO_CHECK: begin
        next_stat = `DCO_ST_READY;
        next_state = DCO_DONE;
        // R11 restriction check
        // R13 LBA change under HPA
        if (hpa_active && rx_lba != FULL_MAX_LBA) begin
          // R12 reason, word, bit
          next_err = `DCO_ERR_ABORT;
          next_stat = `DCO_ST_READY | `DCO_ST_ERR;
          next_sc = `DCO_RSN_HPA;
          next_ch = `DCO_W_LBA0;
          next_cl = 8'h00;
        end else if (rx_lba > FULL_MAX_LBA) begin
          next_err = `DCO_ERR_ABORT;
          next_stat = `DCO_ST_READY | `DCO_ST_ERR;
          next_sc = `DCO_RSN_BAD;
          next_ch = `DCO_W_LBA0;
          next_cl = 8'h00;
        end else begin
          // R9 cleared bit drops feature
          // R10 extra ones ignored
          next_dma_modes = rx_dma & FULL_DMA;
          next_udma_modes = rx_udma & FULL_UDMA;
          next_cmd_sets = rx_cmd & FULL_CMD;
          next_sata_sets = rx_sata & FULL_SATA;
        end
      end
      DCO_DONE: begin
        next_stat = (command_status_flags & ~`DCO_ST_BUSY) | `DCO_ST_READY;
        next_state = DCO_IDLE;
      end
      default: next_state = DCO_IDLE;
    endcase
  end

  // ************************************************
  // Registers
  // ************************************************
  // R5 lock on power reset only
  always_ff @(posedge clk or negedge power_on_rstn) begin
    if (!power_on_rstn) begin
      frozen <= 1'b0;
    end else begin
      frozen <= next_frozen;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= DCO_IDLE;
      sub <= 8'h00;
      idx <= 9'h000;
      rx_dma <= 16'h0000;
      rx_udma <= 16'h0000;
      rx_cmd <= 16'h0000;
      rx_sata <= 16'h0000;
      rx_lba <= 48'h0;
      data_out <= 16'h0000;
      command_error_flags <= 8'h00;
      command_status_flags <= `DCO_ST_READY;
      sector_count <= 8'h00;
      cyl_high <= 8'h00;
      cyl_low <= 8'h00;
    end else begin
      state <= next_state;
      sub <= next_sub;
      idx <= next_idx;
      rx_dma <= next_rx_dma;
      rx_udma <= next_rx_udma;
      rx_cmd <= next_rx_cmd;
      rx_sata <= next_rx_sata;
      rx_lba <= next_rx_lba;
      data_out <= next_data_out;
      command_error_flags <= next_err;
      command_status_flags <= next_stat;
      sector_count <= next_sc;
      cyl_high <= next_ch;
      cyl_low <= next_cl;
    end
  end

  // Capability state survives soft reset only when power stays; kept with lock
  always_ff @(posedge clk or negedge power_on_rstn) begin
    if (!power_on_rstn) begin
      dma_modes <= FULL_DMA;
      udma_modes <= FULL_UDMA;
      cmd_sets <= FULL_CMD;
      sata_sets <= FULL_SATA;
    end else begin
      dma_modes <= next_dma_modes;
      udma_modes <= next_udma_modes;
      cmd_sets <= next_cmd_sets;
      sata_sets <= next_sata_sets;
    end
  end

  // R7 ordinary identify sees reduced set
  always_ff @(posedge clk or negedge power_on_rstn) begin
    if (!power_on_rstn) begin
      ident_words <= '0;
    end else begin
      ident_words <= '{w63: {8'h00, next_dma_modes[7:0]}, w82: next_cmd_sets,
                       w83: {next_cmd_sets[15:8], 8'h00}, w84: next_sata_sets,
                       w88: {8'h00, next_udma_modes[7:0]}};
    end
  end
endmodule : dco_cmd_handler

// >>> verification/dco_chk_assertions.sv
// Checker for the overlay command handler ports
`timescale 1ns/1ps
module dco_chk import dco_pkg::*; #(
  parameter logic [15:0] FULL_DMA = 16'h0007,
  parameter logic [15:0] FULL_UDMA = 16'h007f
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic power_on_rstn,
  // Taskfile inputs
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] feature,
  // Taskfile results
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] command_status_flags,
  input wire logic [7:0] sector_count,
  input wire logic [7:0] cyl_high,
  input wire logic [7:0] cyl_low,
  // Capabilities
  input wire logic [15:0] dma_modes,
  input wire logic [15:0] udma_modes,
  input wire logic frozen
);
  logic idle;
  logic ovl;
  // Busy and DRQ low: a new command is taken
  assign idle = !command_status_flags[7] && !command_status_flags[3];
  assign ovl = cmd_wr && idle && cmd_code == 8'hb1;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn || !power_on_rstn);
  // ****
  // Properties
  // ****
  chk_busy_taken: assert property (ovl |-> ##[1:2] command_status_flags[7])
    else $error("no busy after overlay command");
  chk_other_ignored: assert property (cmd_wr && idle && cmd_code != 8'hb1
    |=> $stable(command_status_flags) [*2]) else $error("foreign opcode moved status");
  chk_abort_only: assert property (command_status_flags[0]
    |-> command_error_flags == 8'h04) else $error("error flags not abort only");
  chk_hpa_code: assert property ($rose(command_status_flags[0]) && sector_count == 8'h06
    |-> cyl_high == 8'h03 && cyl_low == 8'h00) else $error("protected area codes wrong");
  // Only power removal may end the lock, so soft reset stays live here
  chk_lock_kept: assert property (disable iff (!power_on_rstn) frozen |=> frozen)
    else $error("lock lost without power reset");
  chk_lock_aborts: assert property (ovl && frozen |-> ##[2:3] command_status_flags[0])
    else $error("locked command not aborted");
  chk_reserved_abort: assert property (ovl && feature[7:2] != 6'h30
    |-> ##[2:3] command_status_flags[0]) else $error("reserved feature not aborted");
  chk_modes_subset: assert property ((dma_modes & ~FULL_DMA) == 16'h0000
    && (udma_modes & ~FULL_UDMA) == 16'h0000) else $error("mode beyond full set");
  cover property (ovl && feature == 8'hc3);
  cover property (ovl && frozen);
  cover property ($rose(command_status_flags[0]) && sector_count == 8'h06);
endmodule : dco_chk

bind dco_cmd_handler dco_chk #(.FULL_DMA(FULL_DMA), .FULL_UDMA(FULL_UDMA)) i_chk (
  .clk, .rstn, .power_on_rstn, .cmd_wr, .cmd_code, .feature, .command_error_flags,
  .command_status_flags, .sector_count, .cyl_high, .cyl_low, .dma_modes, .udma_modes,
  .frozen
);

// >>> verification/dco_host.sv
// Host model: taskfile writes and PIO block transfers
`timescale 1ns/1ps
module dco_host import dco_pkg::*; (
  // Clock
  input wire logic clk,
  // Taskfile
  output logic cmd_wr,
  output logic [7:0] cmd_code,
  output logic [7:0] feature,
  // PIO data
  output logic data_rd,
  output logic data_wr,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic [7:0] command_status_flags
);
  logic [15:0] blk [256];
  initial begin
    cmd_wr = 1'b0;
    cmd_code = 8'h00;
    feature = 8'h00;
    data_rd = 1'b0;
    data_wr = 1'b0;
    data_in = 16'h0000;
  end
  // Bounded wait so a stuck busy cannot hang the host
  task automatic settle();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (command_status_flags[7] && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : settle
  task automatic issue(input logic [7:0] c, input logic [7:0] f);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    feature <= f;
    @(posedge clk);
    cmd_wr <= 1'b0;
    settle();
  endtask : issue
  task automatic rd_blk();
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      blk[i] = data_out;
      data_rd <= 1'b1;
      @(posedge clk);
      data_rd <= 1'b0;
    end
    settle();
  endtask : rd_blk
  // Released data lines show the inverse, never the stale word
  task automatic wr_blk();
    for (int i = 0; i < 256; i++) begin
      @(posedge clk);
      data_wr <= 1'b1;
      data_in <= blk[i];
      @(posedge clk);
      data_wr <= 1'b0;
      data_in <= ~blk[i];
    end
    settle();
  endtask : wr_blk
endmodule : dco_host

// >>> verification/dco_cmd_handler_tb.sv
// Testbench for the overlay command handler
`timescale 1ns/1ps
module dco_cmd_handler_tb import dco_pkg::*;;
  localparam logic [15:0] DMA = 16'h0007;
  localparam logic [15:0] UDMA = 16'h007f;
  localparam logic [15:0] CMD = 16'h1bbf;
  localparam logic [15:0] SATA = 16'h0017;
  logic clk;
  logic rstn;
  logic power_on_rstn;
  logic hpa_active;
  logic cmd_wr, data_rd, data_wr, frozen;
  logic [7:0] cmd_code, feature, st, ef, sc, ch, cl;
  logic [15:0] data_in, data_out, dma, udma, cs, ss;
  dco_ident_t idw;
  int err_count;
  int checked;
  dco_cmd_handler #(
    .FULL_DMA(DMA), .FULL_UDMA(UDMA), .FULL_CMD(CMD), .FULL_SATA(SATA)
  ) i_dut (
    .clk(clk), .rstn(rstn), .power_on_rstn(power_on_rstn), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .feature(feature), .hpa_active(hpa_active), .data_rd(data_rd),
    .data_wr(data_wr), .data_in(data_in), .data_out(data_out), .command_error_flags(ef),
    .command_status_flags(st), .sector_count(sc), .cyl_high(ch), .cyl_low(cl),
    .ident_words(idw), .dma_modes(dma), .udma_modes(udma), .cmd_sets(cs), .sata_sets(ss),
    .frozen(frozen)
  );
  dco_host i_host (
    .clk(clk), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .feature(feature), .data_rd(data_rd),
    .data_wr(data_wr), .data_in(data_in), .data_out(data_out), .command_status_flags(st)
  );
  always #50 clk = ~clk;
  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp
  function automatic logic [7:0] blk_sum();
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 256; i++) begin
      s = s + i_host.blk[i][15:8] + i_host.blk[i][7:0];
    end
    return s;
  endfunction : blk_sum
  // ****
  // Watchdog: about ten times the expected run
  // ****
  initial begin
    #3000000;
    err_count++;
    stop_test();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    power_on_rstn = 1'b0;
    hpa_active = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    power_on_rstn <= 1'b1;
    i_host.issue(8'hb1, 8'hc2);
    cmp({8'h00, st}, 16'h0048, "identify drq");
    i_host.rd_blk();
    cmp({8'h00, st}, 16'h0040, "identify end");
    cmp({8'h00, i_host.blk[255][7:0]}, 16'h00a5, "signature");
    cmp({8'h00, blk_sum()}, 16'h0000, "checksum");
    cmp(i_host.blk[1], DMA, "full dma");
    // Drop DMA mode 2, offer an unknown UDMA bit
    i_host.blk[1] = 16'h0003;
    i_host.blk[2] = 16'h00ff;
    i_host.blk[255][15:8] = 8'h00;
    i_host.blk[255][15:8] = 8'h00 - blk_sum();
    i_host.issue(8'hb1, 8'hc3);
    cmp({8'h00, st}, 16'h0048, "set drq");
    i_host.wr_blk();
    cmp({8'h00, st}, 16'h0040, "set end");
    cmp(dma, 16'h0003, "dma reduced");
    cmp(udma, UDMA, "udma extra bit");
    cmp(cs, CMD, "cmd sets kept");
    cmp(ss, SATA, "sata sets kept");
    cmp(idw.w63, 16'h0003, "ordinary identify dma");
    cmp(idw.w82, CMD, "ordinary identify cmd");
    cmp(idw.w88, UDMA, "ordinary identify udma");
    i_host.issue(8'hb1, 8'hc2);
    i_host.rd_blk();
    cmp(i_host.blk[1], DMA, "overlay identify full");
    i_host.issue(8'hec, 8'hc0);
    cmp({8'h00, st}, 16'h0040, "foreign opcode");
    cmp(dma, 16'h0003, "foreign opcode dma");
    @(posedge clk);
    hpa_active <= 1'b1;
    i_host.issue(8'hb1, 8'hc0);
    cmp({8'h00, st}, 16'h0041, "hpa abort");
    cmp({sc, ch}, 16'h0603, "hpa reason word");
    cmp({8'h00, cl}, 16'h0000, "hpa bit");
    cmp({8'h00, ef}, 16'h0004, "hpa flags");
    // Shrink max address while the protected area stands
    i_host.blk[4] = 16'h0fff;
    i_host.blk[255][15:8] = 8'h00;
    i_host.blk[255][15:8] = 8'h00 - blk_sum();
    i_host.issue(8'hb1, 8'hc3);
    i_host.wr_blk();
    cmp({8'h00, st}, 16'h0041, "hpa set abort");
    cmp({sc, ch}, 16'h0603, "hpa set reason word");
    cmp({8'h00, cl}, 16'h0000, "hpa set bit");
    cmp(dma, 16'h0003, "aborted set keeps dma");
    @(posedge clk);
    hpa_active <= 1'b0;
    i_host.issue(8'hb1, 8'hc0);
    cmp({8'h00, st}, 16'h0040, "restore");
    cmp(dma, DMA, "restore dma");
    i_host.issue(8'hb1, 8'hc4);
    cmp({8'h00, st}, 16'h0041, "reserved");
    cmp({8'h00, ef}, 16'h0004, "reserved flags");
    i_host.issue(8'hb1, 8'hc1);
    cmp({8'h00, st}, 16'h0040, "freeze");
    cmp({15'h0000, frozen}, 16'h0001, "frozen");
    for (int f = 0; f < 4; f++) begin
      i_host.issue(8'hb1, 8'hc0 + f[7:0]);
      cmp({8'h00, st}, 16'h0041, "locked subcommand");
    end
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    i_host.issue(8'hb1, 8'hc2);
    cmp({8'h00, st}, 16'h0041, "lock after soft reset");
    @(posedge clk);
    power_on_rstn <= 1'b0;
    @(posedge clk);
    power_on_rstn <= 1'b1;
    i_host.issue(8'hb1, 8'hc2);
    cmp({8'h00, st}, 16'h0048, "unlock on power");
    i_host.rd_blk();
    stop_test();
  end
endmodule : dco_cmd_handler_tb
